/* core_model.sv */
// core model: notes each first fetch and counts watchdog ticks
// assumes the sequencer's core-side outputs as inputs
module core_model (
   // clock
   input  wire logic        clock_i,
   // sequencer outputs watched
   input  wire logic        fetch_i,
   input  wire logic        tick_i,
   input  wire logic [15:0] pc_i,
   // what the core saw
   output logic [15:0]      addr_o,
   output int               fetches_o = 0,
   output int               ticks_o = 0
);
   timeunit 1ns;
   timeprecision 1ns;
   // fetch from wherever pc points at start
   always @(posedge clock_i) begin
      if (fetch_i) addr_o <= pc_i;
      fetches_o <= fetches_o + int'(fetch_i);
      ticks_o <= ticks_o + int'(tick_i);
   end
endmodule

/* reset_state_entry_exit.sv */
// reset-state entry and exit control for a small controller
// assumes core, ports, oscillator mux and watchdog obey the controls it drives
// Functional notes
// - while reset is active the core is held halted.
// - during reset every special function register takes its reset value.
// - during reset the port pins are forced to a fixed known state.
// - during reset all interrupts and timers are disabled.
// - reset never writes or clears internal data memory.
// - the stack pointer returns to its reset value though stack data stays.
// - port latches go to all ones with open-drain outputs on reset.
// - weak pullups are on during reset and stay on after it.
// - supply-monitor and power-on resets drive the reset pin low until exit.
// - on exit the program counter is cleared to its reset value.
// - on exit the internal oscillator is the system clock source.
// - on exit the watchdog runs enabled from system clock divided by twelve.
// - the first fetch after release is from address zero.
module reset_state_entry_exit
   import rst_seq_pkg::*;
#(
   parameter int DIV = WDT_DIV
) (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // reset sources, active high (pin source already active high)
   input  wire logic             por_i,
   input  wire logic             vmon_i,
   input  wire logic             pin_rst_i,
   input  wire logic             soft_rst_i,
   // core control
   output logic                  core_halt_o,
   output logic                  sfr_load_o,
   output logic [15:0]           pc_o,
   output logic [7:0]            sp_o,
   output logic                  fetch_start_o,
   output logic                  ram_wr_block_o,
   // interrupts and timers
   output logic                  irq_disable_o,
   output logic                  timer_disable_o,
   // ports
   output logic [7:0]            port_latch_o,
   output logic                  port_open_drain_o,
   output logic                  weak_pullup_o,
   // external reset pin, open drain
   output logic                  rst_pin_o,
   output logic                  rst_pin_oe_o,
   // clocking and watchdog
   output logic [1:0]            clk_sel_o,
   output logic                  wdt_enable_o,
   output logic                  wdt_tick_o,
   output logic [SRC_W-1:0]      rst_cause_o
);
   import rst_seq_pkg::*;

   // two states only; one-hot, so a stray code falls back to reset
   typedef enum logic [1:0] {
      ST_RESET = 2'b01,
      ST_RUN   = 2'b10
   } state_t;

   // sequencing state and synchronisers
   state_t             state;
   state_t             next_state;
   logic               rst_sync1;
   logic               rst_sync2;
   logic [SRC_W-1:0]   src_s1;
   logic [SRC_W-1:0]   src_s2;
   logic               any_src;
   // exit bookkeeping
   logic               drive_pin;
   logic               was_reset;
   logic               tick;

   // assertion stays asynchronous so a stopped clock still resets
   // reset release through two flops
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync1 <= 1'b0;
         rst_sync2 <= 1'b0;
      end else begin
         rst_sync1 <= 1'b1;
         rst_sync2 <= rst_sync1;
      end
   end

   // a source pulse shorter than one clock may be missed
   // sources come from other domains, two flops each
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         src_s1 <= '0;
         src_s2 <= '0;
      end else begin
         src_s1 <= {soft_rst_i, pin_rst_i, vmon_i, por_i};
         src_s2 <= src_s1;
      end
   end

   // any synchronised source keeps the block in reset
   assign any_src = |src_s2;

   // hold while any source stays active, leave on a clock edge
   always_comb begin
      next_state = state;
      unique case (state)
         ST_RESET: if (!any_src) next_state = ST_RUN;
         ST_RUN:   if (any_src) next_state = ST_RESET;
         default:  next_state = ST_RESET;
      endcase
   end

   // state register
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) state <= ST_RESET;
      else            state <= next_state;
   end

   // supply and power-on resets own the pin until the exit edge
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         drive_pin <= 1'b1;  // chip-level reset counts as power-on
      end else if (any_src) begin
         // once set, a later pin or soft source cannot take the pin back
         drive_pin <= src_s2[SRC_POR] | src_s2[SRC_VMON] | (drive_pin && state == ST_RESET);
      end else if (next_state == ST_RUN) begin
         drive_pin <= 1'b0;
      end
   end

   // last seen source pattern, kept after exit so the cause can be read
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         rst_cause_o <= '0;
      end else if (any_src) begin
         rst_cause_o <= src_s2;
      end
   end

   // notes that the previous edge was still in reset
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         was_reset <= 1'b1;
      end else begin
         was_reset <= (state == ST_RESET);
      end
   end

   // one-cycle fetch start on the edge after the exit edge; pc already sits at zero
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         fetch_start_o <= 1'b0;
      end else begin
         fetch_start_o <= was_reset && (state == ST_RUN);
      end
   end

   // program counter parked at its reset value while held
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         pc_o <= PC_RST;
      end else if (state == ST_RESET) begin
         pc_o <= PC_RST;
      end
   end

   // stack pointer reloaded; the stack bytes in memory are left alone
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         sp_o <= SP_RST;
      end else if (state == ST_RESET) begin
         sp_o <= SP_RST;
      end
   end

   // port latches to all ones; pins then sit high on the pullups
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         port_latch_o <= PORT_LATCH_RST;
      end else if (state == ST_RESET) begin
         port_latch_o <= PORT_LATCH_RST;
      end
   end

   // system clock back on the internal oscillator
   always_ff @(posedge clock_i or negedge rst_sync2) begin
      if (!rst_sync2) begin
         clk_sel_o <= CLK_SEL_INT;
      end else if (state == ST_RESET) begin
         clk_sel_o <= CLK_SEL_INT;
      end
   end

   // core held and registers loaded for as long as the state says reset
   assign core_halt_o       = (state == ST_RESET);
   assign sfr_load_o        = (state == ST_RESET);

   // no interrupt request or timer count slips through while held
   assign irq_disable_o     = (state == ST_RESET);
   assign timer_disable_o   = (state == ST_RESET);

   // port mode is the reset default; it stays tied there after exit as well
   assign port_open_drain_o = 1'b1;
   assign weak_pullup_o     = 1'b1;

   // memory is never touched by reset; writes blocked while halted
   assign ram_wr_block_o    = (state == ST_RESET);

   // open-drain reset pin: only ever pulls low, the enable says when
   assign rst_pin_o         = 1'b0;
   assign rst_pin_oe_o      = drive_pin && (state == ST_RESET);

   // watchdog runs from the first edge out of reset
   assign wdt_enable_o      = (state == ST_RUN);
   assign wdt_tick_o        = tick;

   // watchdog clock at system clock over twelve; the divider restarts
   // each time reset is entered, so the first tick is a full period after exit
   wdt_prescale #(.DIV(DIV)) u_wdt_div (
      .clock_i (clock_i),
      .rst_n_i (rst_sync2),
      .run_i   (wdt_enable_o),
      .tick_o  (tick)
   );
endmodule

/* rst_seq_checker.sv */
// checker: reset entry and exit at the sequencer ports
// assumes it is bound into reset_state_entry_exit
module rst_seq_checker
   import rst_seq_pkg::*;
#(
   parameter int DIV = WDT_DIV
) (
   // clock and chip reset
   input  wire logic        clock_i,
   input  wire logic        rst_n_i,
   // reset sources
   input  wire logic        por_i,
   input  wire logic        vmon_i,
   input  wire logic        pin_rst_i,
   input  wire logic        soft_rst_i,
   // core, interrupt and memory controls
   input  wire logic        core_halt_o,
   input  wire logic        sfr_load_o,
   input  wire logic        fetch_start_o,
   input  wire logic        ram_wr_block_o,
   input  wire logic        irq_disable_o,
   input  wire logic        timer_disable_o,
   input  wire logic [15:0] pc_o,
   input  wire logic [7:0]  sp_o,
   // ports and reset pin
   input  wire logic        port_open_drain_o,
   input  wire logic        weak_pullup_o,
   input  wire logic [7:0]  port_latch_o,
   input  wire logic        rst_pin_o,
   input  wire logic        rst_pin_oe_o,
   // clocking and watchdog
   input  wire logic [1:0]  clk_sel_o,
   input  wire logic        wdt_enable_o,
   input  wire logic        wdt_tick_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   wire src = por_i | vmon_i | pin_rst_i | soft_rst_i;
   int gap; // cycles since a tick; a counter lets DIV vary
   always_ff @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i) gap <= -1;
      else gap <= !wdt_enable_o ? -1 : wdt_tick_o ? 0 : gap + int'(gap >= 0);
   chk_halt_entry: assert property (src |-> ##[1:4] core_halt_o) else $error("halt");
   chk_halt_ctl: assert property
      (core_halt_o |-> sfr_load_o && irq_disable_o && timer_disable_o && ram_wr_block_o) else $error("ctl");
   chk_reset_regs: assert property
      (core_halt_o [*2] |-> sp_o == SP_RST && port_latch_o == PORT_LATCH_RST && pc_o == PC_RST) else $error("regs");
   chk_pin_mode: assert property (port_open_drain_o && weak_pullup_o && !rst_pin_o) else $error("mode");
   chk_pin_drive: assert property (por_i || vmon_i |-> ##[1:4] rst_pin_oe_o) else $error("drive");
   chk_exit_fetch: assert property
      ($fell(core_halt_o) |=> fetch_start_o && pc_o == PC_RST) else $error("fetch");
   chk_exit_state: assert property
      (!core_halt_o |-> clk_sel_o == CLK_SEL_INT && wdt_enable_o && !rst_pin_oe_o) else $error("run");
   chk_wdt_period: assert property
      (wdt_enable_o && gap >= 0 |-> gap < DIV && (!wdt_tick_o || gap == DIV - 1)) else $error("wdt");
   chk_release_sync: assert property ((!src) [*4] |-> !core_halt_o) else $error("release");
   cover property ($fell(core_halt_o));
   cover property (pin_rst_i && core_halt_o && !rst_pin_oe_o);
   cover property (wdt_tick_o && gap == DIV - 1);
endmodule
bind reset_state_entry_exit rst_seq_checker #(.DIV(DIV)) i_rst_seq_checker (.*);

/* rst_seq_pkg.sv */
// constants for the reset-state sequencer
// assumes a single 20 MHz system clock domain
package rst_seq_pkg;
   localparam int        CLOCK_HZ        = 20_000_000;
   localparam logic [7:0] PORT_LATCH_RST = 8'hff;
   localparam logic [15:0] PC_RST        = 16'h0000;
   localparam logic [7:0] SP_RST         = 8'h07;
   localparam logic [7:0] SFR_RST        = 8'h00;
   localparam int        WDT_DIV         = 12;
   localparam int        WDT_CNT_W       = 4;
   localparam logic [1:0] CLK_SEL_INT    = 2'h0;
   localparam int        SRC_W           = 4;
   // source bit positions
   localparam int        SRC_POR         = 0;
   localparam int        SRC_VMON        = 1;
   localparam int        SRC_PIN         = 2;
   localparam int        SRC_SOFT        = 3;
endpackage

/* testbench.sv */
// testbench: reset sources in, reset state and exit judged
// assumes package, design, core_model and checker compiled first
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import rst_seq_pkg::*;
   logic clock_i = 0, rst_n_i = 0, por_i, vmon_i, pin_rst_i, soft_rst_i, core_halt_o, sfr_load_o;
   logic fetch_start_o, ram_wr_block_o, irq_disable_o, timer_disable_o, port_open_drain_o, weak_pullup_o;
   logic rst_pin_o, rst_pin_oe_o, wdt_enable_o, wdt_tick_o;
   logic [15:0] pc_o, addr;
   logic [7:0] sp_o, port_latch_o;
   logic [3:0] rst_cause_o, src = 0;
   logic [1:0] clk_sel_o;
   int fetches, ticks, t0, err_count = 0, samples_checked = 0;
   assign {soft_rst_i, pin_rst_i, vmon_i, por_i} = src;
   always #25 clock_i = ~clock_i;
   reset_state_entry_exit i_reset_state_entry_exit (.*);
   core_model i_core_model (.clock_i, .fetch_i(fetch_start_o), .tick_i(wdt_tick_o), .pc_i(pc_o),
      .addr_o(addr), .fetches_o(fetches), .ticks_o(ticks));
   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task automatic check(input string s, input logic [15:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("%0d checks, %0d mismatches", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // chip reset exit, then each source alone in and out
   task automatic t_sources;
      cyc(8);
      check("boot", {core_halt_o, clk_sel_o}, 0);
      check("fetch", addr, PC_RST);
      for (int k = 0; k < 4; k++) begin
         src[k] = 1;
         cyc(6);
         check("hold", {core_halt_o, sfr_load_o, irq_disable_o, timer_disable_o, ram_wr_block_o}, 5'h1f);
         check("regs", {sp_o, port_latch_o}, {SP_RST, 8'hff});
         check("pin", rst_pin_oe_o, k < 2);
         check("cause", rst_cause_o, 4'h1 << k);
         src[k] = 0;
         cyc(6);
         check("exit", {fetches[3:0], core_halt_o, rst_pin_oe_o, wdt_enable_o}, {k[3:0] + 4'h2, 3'h1});
      end
      $display("sources done");
   endtask
   // power-on drops first, yet the pin stays low to the exit
   task automatic t_overlap;
      src = 4'h9;
      cyc(5);
      src = 4'h8;
      cyc(6);
      check("held", {core_halt_o, rst_pin_oe_o}, 2'h3);
      src = 0;
      cyc(6);
      check("freed", core_halt_o, 0);
      t0 = ticks;
      cyc(120);
      check("ticks", ticks - t0, 120 / WDT_DIV);
      $display("overlap and watchdog done");
   endtask
   // chip reset in mid-run: pin driven as for power-on, then a clean boot
   task automatic t_chip_reset;
      int f0;
      f0 = fetches;
      rst_n_i = 0;
      cyc(2);
      check("chip hold", {core_halt_o, rst_pin_oe_o, wdt_enable_o}, 3'h6);
      check("chip pc", pc_o, PC_RST);
      check("chip latch", port_latch_o, PORT_LATCH_RST);
      check("chip mode", {port_open_drain_o, weak_pullup_o, rst_pin_o}, 3'h6);
      rst_n_i = 1;
      cyc(8);
      check("chip fetch", fetches - f0, 1);
      check("chip run", {core_halt_o, rst_pin_oe_o, wdt_enable_o, clk_sel_o}, {3'h1, CLK_SEL_INT});
      $display("chip reset done");
   endtask
   initial begin
      cyc(16);
      rst_n_i = 1;
      t_sources;
      t_overlap;
      t_chip_reset;
      tally_and_finish;
   end
   // tests take about 220 cycles, so 2000 means a hang
   initial begin
      cyc(2000);
      err_count++;
      tally_and_finish;
   end
endmodule

/* wdt_prescale.sv */
// divide-by-n enable pulse generator for the watchdog clock
// assumes the enclosing logic holds it cleared while in reset
module wdt_prescale #(
   parameter int DIV = rst_seq_pkg::WDT_DIV
) (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // control
   input  wire logic run_i,
   output logic      tick_o
);
   import rst_seq_pkg::*;
   logic [WDT_CNT_W-1:0] count;

   // counter restarts from zero whenever run drops
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else if (!run_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else if (count == WDT_CNT_W'(DIV - 1)) begin
         count  <= '0;
         tick_o <= 1'b1;
      end else begin
         count  <= count + 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule
